/* ppo_power_ctl.sv */
// Downstream port power enable and overcurrent control with register port and interrupt
// Operation
// - Enabled port keeps its combined pin an input with pull-up, powering the port.
// - Enabled port samples its combined pin; low level means overcurrent.
// - Disabled port, by configuration or host, drives its combined pin low.
// - Ports 2-4: pin powers both portions unless split mode, then USB 2.0 only.
// - Port 1: pin always powers both portions; no split alternative.
// - Split mode drives active-high USB 3.2 power enables for ports 3 and 4.
// - Split mode off leaves the dedicated enables unused, held low.
// - Port 2 also has a dedicated active-high enable under split mode.
`timescale 1ns/1ps
module ppo_power_ctl #(
    parameter int unsigned SETTLE_CYC = ppo_pkg::SETTLE_CYC
) (
    input  wire logic        clk_in,                   // Core clock, 25 MHz
    input  wire logic        rstn_in,                  // Asynchronous reset, active low
    input  wire logic [7:0]  reg_addr_in,              // Register byte address
    input  wire logic [31:0] reg_wdata_in,             // Register write data
    input  wire logic        reg_wr_in,                // Write strobe
    input  wire logic        reg_rd_in,                // Read strobe
    output logic      [31:0] reg_rdata_out,            // Read data, cycle after strobe
    input  wire logic [3:0]  host_port_off_in,         // Host request to power off a port
    input  wire logic        port1_power_sense_in,     // Port 1 combined pin level
    output logic             port1_power_sense_out,    // Port 1 drive value
    output logic             port1_power_sense_oe_out, // Port 1 drive enable
    output logic             port1_power_sense_pu_out, // Port 1 pull-up enable
    input  wire logic        port2_power_sense_in,     // Port 2 combined pin level
    output logic             port2_power_sense_out,    // Port 2 drive value
    output logic             port2_power_sense_oe_out, // Port 2 drive enable
    output logic             port2_power_sense_pu_out, // Port 2 pull-up enable
    input  wire logic        port3_power_sense_in,     // Port 3 combined pin level
    output logic             port3_power_sense_out,    // Port 3 drive value
    output logic             port3_power_sense_oe_out, // Port 3 drive enable
    output logic             port3_power_sense_pu_out, // Port 3 pull-up enable
    input  wire logic        port4_power_sense_in,     // Port 4 combined pin level
    output logic             port4_power_sense_out,    // Port 4 drive value
    output logic             port4_power_sense_oe_out, // Port 4 drive enable
    output logic             port4_power_sense_pu_out, // Port 4 pull-up enable
    output logic             port2_hs_power_en_out,    // Port 2 USB 3.2 power, active high
    output logic             port3_hs_power_en_out,    // Port 3 USB 3.2 power, active high
    output logic             port4_hs_power_en_out,    // Port 4 USB 3.2 power, active high
    output logic      [3:0]  oc_status_out,            // Live overcurrent per port
    output logic      [3:0]  ss_power_on_out,          // USB 3.2 portion powered per port
    output logic             irq_out                   // Interrupt, active high level
);

    localparam int unsigned NP = ppo_pkg::NUM_PORTS;
    localparam int unsigned NH = ppo_pkg::NUM_HS_PORTS;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [NP-1:0] port_en_ff;
    logic          split_ff;
    logic [NH-1:0] hs_en_ff;
    logic [NP-1:0] int_stat_ff;
    logic [NP-1:0] int_mask_ff;
    logic [NP-1:0] oc_prev_ff;
    logic [NH-1:0] hs_pin_ff;
    logic [NP-1:0] ss_ff;
    logic          irq_ff;
    logic [31:0]   rdata_ff;

    logic [NP-1:0] en_eff;
    logic [NP-1:0] pin_lvl;
    logic [NP-1:0] pin_drv;
    logic [NP-1:0] pin_oe;
    logic [NP-1:0] pin_pu;
    logic [NP-1:0] oc_live;
    logic [NP-1:0] oc_rise;
    logic [NP-1:0] nxt_int_stat;
    logic [NH-1:0] nxt_hs_pin;
    logic [NP-1:0] nxt_ss;
    logic [31:0]   nxt_rdata;
    logic          wr_ctrl;
    logic          wr_stat;
    logic          wr_mask;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    assign wr_ctrl = reg_wr_in && (reg_addr_in == ppo_pkg::ADDR_CTRL);
    assign wr_stat = reg_wr_in && (reg_addr_in == ppo_pkg::ADDR_INT_STAT);
    assign wr_mask = reg_wr_in && (reg_addr_in == ppo_pkg::ADDR_INT_MASK);

    // Control register: enables, split mode, high-speed enables
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            port_en_ff <= ppo_pkg::RST_PORT_EN;
            split_ff   <= ppo_pkg::RST_SPLIT;
            hs_en_ff   <= ppo_pkg::RST_HS_EN;
        end else if (wr_ctrl) begin
            port_en_ff <= reg_wdata_in[ppo_pkg::CTRL_EN_LSB +: NP];
            split_ff   <= reg_wdata_in[ppo_pkg::CTRL_SPLIT];
            hs_en_ff   <= reg_wdata_in[ppo_pkg::CTRL_HS_LSB +: NH];
        end
    end

    // Interrupt mask register
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            int_mask_ff <= ppo_pkg::RST_INT_MASK;
        end else if (wr_mask) begin
            int_mask_ff <= reg_wdata_in[NP-1:0];
        end
    end

    // ------------------------------------------------------------
    // Port enable and per-port pin logic
    // ------------------------------------------------------------
    // A port is on only if configured on and not switched off by the host
    assign en_eff = port_en_ff & ~host_port_off_in;

    assign pin_lvl = {port4_power_sense_in, port3_power_sense_in,
                      port2_power_sense_in, port1_power_sense_in};

    // One pin controller for each combined pin
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_port
            ppo_port_ctl #(
                .SETTLE_CYC (SETTLE_CYC),
                .CNT_W      (ppo_pkg::SETTLE_CNT_W)
            ) u_port (
                .clk_in     (clk_in),
                .rstn_in    (rstn_in),
                .enable_in  (en_eff[gi]),
                .pin_in     (pin_lvl[gi]),
                .pin_out    (pin_drv[gi]),
                .pin_oe_out (pin_oe[gi]),
                .pin_pu_out (pin_pu[gi]),
                .oc_out     (oc_live[gi])
            );
        end
    endgenerate

    // Pin outputs, each from a flip-flop in its controller
    assign port1_power_sense_out    = pin_drv[0];
    assign port1_power_sense_oe_out = pin_oe[0];
    assign port1_power_sense_pu_out = pin_pu[0];
    assign port2_power_sense_out    = pin_drv[1];
    assign port2_power_sense_oe_out = pin_oe[1];
    assign port2_power_sense_pu_out = pin_pu[1];
    assign port3_power_sense_out    = pin_drv[2];
    assign port3_power_sense_oe_out = pin_oe[2];
    assign port3_power_sense_pu_out = pin_pu[2];
    assign port4_power_sense_out    = pin_drv[3];
    assign port4_power_sense_oe_out = pin_oe[3];
    assign port4_power_sense_pu_out = pin_pu[3];
    assign oc_status_out            = oc_live;

    // ------------------------------------------------------------
    // Split-port power routing
    // ------------------------------------------------------------
    // Dedicated enables follow their port and its high-speed enable bit only in split mode, else held low
    always_comb begin
        if (split_ff) begin
            nxt_hs_pin = hs_en_ff & en_eff[NP-1:1];
        end else begin
            nxt_hs_pin = '0;
        end
    end

    // USB 3.2 portion powered: port 1 by its pin, ports 2-4 by pin or split enable
    always_comb begin
        nxt_ss[0] = pin_pu[0];
        if (split_ff) begin
            nxt_ss[NP-1:1] = hs_pin_ff;
        end else begin
            nxt_ss[NP-1:1] = pin_pu[NP-1:1];
        end
    end

    // Registered split outputs
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hs_pin_ff <= '0;
            ss_ff     <= '0;
        end else begin
            hs_pin_ff <= nxt_hs_pin;
            ss_ff     <= nxt_ss;
        end
    end

    assign port2_hs_power_en_out = hs_pin_ff[0];
    assign port3_hs_power_en_out = hs_pin_ff[1];
    assign port4_hs_power_en_out = hs_pin_ff[2];
    assign ss_power_on_out       = ss_ff;

    // ------------------------------------------------------------
    // Overcurrent events and interrupt
    // ------------------------------------------------------------
    assign oc_rise = oc_live & ~oc_prev_ff;

    // Sticky status, a new event wins over a clear in the same cycle
    always_comb begin
        nxt_int_stat = int_stat_ff;
        if (wr_stat) begin
            nxt_int_stat = int_stat_ff & ~reg_wdata_in[NP-1:0];
        end
        nxt_int_stat = nxt_int_stat | oc_rise;
    end

    // Status flops and edge memory
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            oc_prev_ff  <= '0;
            int_stat_ff <= '0;
        end else begin
            oc_prev_ff  <= oc_live;
            int_stat_ff <= nxt_int_stat;
        end
    end

    // Level interrupt while any unmasked event is pending
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(int_stat_ff & int_mask_ff);
        end
    end

    assign irq_out = irq_ff;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Read mux, unmapped addresses and idle cycles read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                ppo_pkg::ADDR_CTRL: begin
                    nxt_rdata[ppo_pkg::CTRL_EN_LSB +: NP] = port_en_ff;
                    nxt_rdata[ppo_pkg::CTRL_SPLIT]        = split_ff;
                    nxt_rdata[ppo_pkg::CTRL_HS_LSB +: NH] = hs_en_ff;
                end
                ppo_pkg::ADDR_STATUS: begin
                    nxt_rdata[ppo_pkg::STAT_OC_LSB +: NP]  = oc_live;
                    nxt_rdata[ppo_pkg::STAT_PWR_LSB +: NP] = pin_pu;
                    nxt_rdata[ppo_pkg::STAT_SS_LSB +: NP]  = ss_ff;
                    nxt_rdata[ppo_pkg::STAT_SPLIT]         = split_ff;
                end
                ppo_pkg::ADDR_INT_STAT: begin
                    nxt_rdata[NP-1:0] = int_stat_ff;
                end
                ppo_pkg::ADDR_INT_MASK: begin
                    nxt_rdata[NP-1:0] = int_mask_ff;
                end
                default: begin
                    nxt_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data stand for one cycle only
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_out = rdata_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_host_off_drives_low;
        @(posedge clk_in) disable iff (!rstn_in)
        (host_port_off_in[0] || !port_en_ff[0]) |=> (port1_power_sense_oe_out && !port1_power_sense_out);
    endproperty
    a_host_off_drives_low: assert property (p_host_off_drives_low) else $error("Port 1 off but pin not low");

    property p_hs_low_unsplit;
        @(posedge clk_in) disable iff (!rstn_in)
        !split_ff |=> (!port2_hs_power_en_out && !port3_hs_power_en_out && !port4_hs_power_en_out);
    endproperty
    a_hs_low_unsplit: assert property (p_hs_low_unsplit) else $error("Dedicated enable high without split");

    property p_hs_port4_on;
        @(posedge clk_in) disable iff (!rstn_in)
        (split_ff && hs_en_ff[2] && en_eff[3]) |=> port4_hs_power_en_out;
    endproperty
    a_hs_port4_on: assert property (p_hs_port4_on) else $error("Port 4 dedicated enable missing");

    property p_hs_port2_on;
        @(posedge clk_in) disable iff (!rstn_in)
        (split_ff && hs_en_ff[0] && en_eff[1]) |=> port2_hs_power_en_out;
    endproperty
    a_hs_port2_on: assert property (p_hs_port2_on) else $error("Port 2 dedicated enable missing");

    property p_port1_ss_follows_pin;
        @(posedge clk_in) disable iff (!rstn_in)
        ##1 (ss_power_on_out[0] == $past(port1_power_sense_pu_out));
    endproperty
    a_port1_ss_follows_pin: assert property (p_port1_ss_follows_pin) else $error("Port 1 USB 3.2 power mismatch");

    property p_ss_unsplit_follows_pin;
        @(posedge clk_in) disable iff (!rstn_in)
        (!split_ff && (pin_pu[3:1] == 3'h7)) |=> (ss_power_on_out[3:1] == 3'h7);
    endproperty
    a_ss_unsplit_follows_pin: assert property (p_ss_unsplit_follows_pin) else $error("Unsplit USB 3.2 power mismatch");

    property p_event_set_wins;
        @(posedge clk_in) disable iff (!rstn_in)
        (oc_rise[1] && wr_stat && reg_wdata_in[1]) |=> int_stat_ff[1];
    endproperty
    a_event_set_wins: assert property (p_event_set_wins) else $error("Overcurrent event lost on clear");

    property p_irq_two_cycles;
        @(posedge clk_in) disable iff (!rstn_in)
        (|(oc_rise & int_mask_ff) && !wr_mask) |-> ##2 irq_out;
    endproperty
    a_irq_two_cycles: assert property (p_irq_two_cycles) else $error("Interrupt not raised after event");

    property p_rdata_one_cycle;
        @(posedge clk_in) disable iff (!rstn_in)
        !reg_rd_in |=> (reg_rdata_out == 32'h0000_0000);
    endproperty
    a_rdata_one_cycle: assert property (p_rdata_one_cycle) else $error("Read data outside read cycle");

endmodule : ppo_power_ctl

/* ppo_pkg.sv */
// Shared constants for the downstream port power and overcurrent control block
package ppo_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_PORTS     = 4;
    localparam int unsigned NUM_HS_PORTS  = 3;      // Ports 2 to 4
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;  // Enables, split mode, high-speed enables
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;  // Live state, read only
    localparam logic [7:0]  ADDR_INT_STAT = 8'h08;  // Sticky overcurrent events, write one to clear
    localparam logic [7:0]  ADDR_INT_MASK = 8'h0c;  // Interrupt mask, same layout

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_EN_LSB   = 0;      // [3:0] port enable
    localparam int unsigned CTRL_SPLIT    = 4;      // Split-port mode
    localparam int unsigned CTRL_HS_LSB   = 5;      // [7:5] high-speed enable, ports 2 to 4
    localparam int unsigned STAT_OC_LSB   = 0;      // [3:0] overcurrent live
    localparam int unsigned STAT_PWR_LSB  = 4;      // [7:4] combined pin pulled up
    localparam int unsigned STAT_SS_LSB   = 8;      // [11:8] USB 3.2 portion powered
    localparam int unsigned STAT_SPLIT    = 12;     // Split mode in force

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  RST_PORT_EN   = 4'h0;   // Ports start disabled, pins driven low
    localparam logic        RST_SPLIT     = 1'b0;
    localparam logic [2:0]  RST_HS_EN     = 3'h0;
    localparam logic [3:0]  RST_INT_MASK  = 4'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;     // 25 MHz core clock
    localparam int unsigned SETTLE_NS     = 1000;   // Pull-up settle blanking after enable
    localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_CNT_W  = 8;

endpackage : ppo_pkg

/* ppo_port_ctl.sv */
// One downstream port: combined power enable / overcurrent sense pin handling
`timescale 1ns/1ps
module ppo_port_ctl #(
    parameter int unsigned SETTLE_CYC = ppo_pkg::SETTLE_CYC,
    parameter int unsigned CNT_W      = ppo_pkg::SETTLE_CNT_W
) (
    input  wire logic clk_in,       // Core clock
    input  wire logic rstn_in,      // Asynchronous reset, active low
    input  wire logic enable_in,    // Port enabled, same clock
    input  wire logic pin_in,       // Level seen on the combined pin
    output logic      pin_out,      // Drive value, always low
    output logic      pin_oe_out,   // High while the pin is driven
    output logic      pin_pu_out,   // Internal pull-up on
    output logic      oc_out        // Qualified overcurrent, active high
);

    localparam logic [CNT_W-1:0] SETTLE_VAL = CNT_W'(SETTLE_CYC);

    logic             sync1_ff;
    logic             sync2_ff;
    logic             en_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             settled;

    assign settled = (cnt_ff == SETTLE_VAL);

    // ------------------------------------------------------------
    // Pin direction and pull-up
    // ------------------------------------------------------------
    // Enabled: input with pull-up; disabled: output driven low
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            en_ff      <= 1'b0;
            pin_pu_out <= 1'b0;
            pin_oe_out <= 1'b1;
            pin_out    <= 1'b0;
        end else begin
            en_ff      <= enable_in;
            pin_pu_out <= enable_in;
            pin_oe_out <= !enable_in;
            pin_out    <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Overcurrent sensing
    // ------------------------------------------------------------
    // Two-stage synchroniser for the pin level
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    // Blanking while the pulled-up level rises after enable
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_ff <= '0;
        end else if (!en_ff) begin
            cnt_ff <= '0;
        end else if (!settled) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // Low level on an enabled, settled port means overcurrent
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            oc_out <= 1'b0;
        end else begin
            oc_out <= en_ff && settled && !sync2_ff;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_pin_pulled_up;
        @(posedge clk_in) disable iff (!rstn_in)
        enable_in |=> (pin_pu_out && !pin_oe_out);
    endproperty
    a_pin_pulled_up: assert property (p_pin_pulled_up) else $error("Enabled port pin not pulled up");

    property p_pin_driven_low;
        @(posedge clk_in) disable iff (!rstn_in)
        !enable_in |=> (pin_oe_out && !pin_out && !pin_pu_out);
    endproperty
    a_pin_driven_low: assert property (p_pin_driven_low) else $error("Disabled port pin not driven low");

    property p_oc_from_low_pin;
        @(posedge clk_in) disable iff (!rstn_in)
        oc_out |-> ($past(!pin_in, 3) && $past(pin_pu_out));
    endproperty
    a_oc_from_low_pin: assert property (p_oc_from_low_pin) else $error("Overcurrent without low enabled pin");

    // Shortest blanking, which holds for any settle count of two or more
    property p_oc_blanked;
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(pin_pu_out) |-> !oc_out [*3];
    endproperty
    a_oc_blanked: assert property (p_oc_blanked) else $error("Overcurrent reported during settle");

endmodule : ppo_port_ctl

/* ppo_switch_model.sv */
// Behavioural external power switch and current monitor for four ports
`timescale 1ns/1ps
module ppo_switch_model (
    input  wire logic       clk_in,    // Core clock
    input  wire logic [3:0] oe_in,     // Device drives the pin
    input  wire logic [3:0] pu_in,     // Device pull-up on
    input  wire logic [3:0] drv_in,    // Device drive value
    input  wire logic [3:0] fault_in,  // Monitor pulls low on overcurrent
    output logic      [3:0] level_out  // Resolved pin level
);
    logic [3:0] last_ff;

    // Remember the level so a floating pin never repeats it
    always_ff @(posedge clk_in) begin
        last_ff <= level_out;
    end

    // Drive wins, then the monitor, then the pull-up; else floating
    // Dedicated enables only feed an embedded device and are not wired here
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            level_out[i] = oe_in[i] ? drv_in[i] : fault_in[i] ? 1'b0 : pu_in[i] ? 1'b1 : ~last_ff[i];
        end
    end
endmodule : ppo_switch_model

/* test_ppo_power_ctl.sv */
// Self-checking bench for the port power and overcurrent block
`timescale 1ns/1ps
module test_ppo_power_ctl;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d = 1'b0;
    logic [3:0]  off = 4'h0;
    logic [3:0]  fault = 4'h0;
    logic [31:0] lf = 32'hb80d;
    logic [31:0] rdata;
    logic [3:0]  lvl, drv, oe, pu, oc, ss;
    logic [2:0]  hs;
    logic        irq;
    logic [31:0] expq[$];
    int          miscompares = 0;
    int          checked = 0;
    int          cyc = 0;
    int          p;

    ppo_power_ctl #(.SETTLE_CYC(2)) DUT (
        .clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .host_port_off_in(off),
        .port1_power_sense_in(lvl[0]), .port1_power_sense_out(drv[0]),
        .port1_power_sense_oe_out(oe[0]), .port1_power_sense_pu_out(pu[0]),
        .port2_power_sense_in(lvl[1]), .port2_power_sense_out(drv[1]),
        .port2_power_sense_oe_out(oe[1]), .port2_power_sense_pu_out(pu[1]),
        .port3_power_sense_in(lvl[2]), .port3_power_sense_out(drv[2]),
        .port3_power_sense_oe_out(oe[2]), .port3_power_sense_pu_out(pu[2]),
        .port4_power_sense_in(lvl[3]), .port4_power_sense_out(drv[3]),
        .port4_power_sense_oe_out(oe[3]), .port4_power_sense_pu_out(pu[3]),
        .port2_hs_power_en_out(hs[0]), .port3_hs_power_en_out(hs[1]), .port4_hs_power_en_out(hs[2]),
        .oc_status_out(oc), .ss_power_on_out(ss), .irq_out(irq));

    ppo_switch_model MDL (.clk_in(clk_in), .oe_in(oe), .pu_in(pu), .drv_in(drv), .fault_in(fault), .level_out(lvl));

    // Free-running 25 MHz clock
    initial begin
        forever #20 clk_in = ~clk_in;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Next value of the stimulus shift register
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    task automatic test_done;
        $display("Counts: checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // One register cycle; a read notes its expected data
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        if (!w) expq.push_back(d);
        @(posedge clk_in);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
    endtask : wt

    // Read data stand the cycle after the strobe; compare with oldest note
    always @(posedge clk_in) begin
        rd_d <= rd;
        if (rd_d) chk("rdata", expq.pop_front(), rdata);
    end

    // Cycle ceiling against a hang
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            test_done;
        end
    end

    // Main sequence
    initial begin
        wt(2);
        rstn_in <= 1'b1;
        chk("oe", 32'hf, 32'(oe));
        chk("drv", 32'h0, 32'(drv));
        bus(0, ppo_pkg::ADDR_CTRL, 32'h0);
        bus(0, 8'h10, 32'h0);
        bus(1, ppo_pkg::ADDR_CTRL, 32'hef);
        wt(4);
        chk("pu", 32'hf, 32'({oe, pu}));
        chk("hs", 32'h0, 32'(hs));
        chk("ss", 32'hf, 32'(ss));
        bus(0, ppo_pkg::ADDR_STATUS, 32'h0ff0);
        $display("Test split off done");
        bus(1, ppo_pkg::ADDR_CTRL, 32'hff);
        wt(4);
        chk("hs", 32'h7, 32'(hs));
        chk("ss", 32'hf, 32'(ss));
        bus(0, ppo_pkg::ADDR_STATUS, 32'h1ff0);
        bus(1, ppo_pkg::ADDR_CTRL, 32'h1f);
        wt(4);
        chk("hs", 32'h0, 32'(hs));
        chk("ss", 32'h1, 32'(ss));
        bus(0, ppo_pkg::ADDR_STATUS, 32'h11f0);
        $display("Test split on done");
        lf = lfsr_next(lf);
        p = int'(lf[1:0]);
        off <= 4'h1 << p;
        wt(3);
        chk("oe", 32'h1 << p, 32'(oe));
        off <= 4'h0;
        wt(6);
        fault <= 4'h1 << p;
        wt(6);
        chk("oc", 32'h1 << p, 32'(oc));
        chk("irq", 32'h0, 32'(irq));
        bus(1, ppo_pkg::ADDR_INT_MASK, 32'hf);
        wt(3);
        chk("irq", 32'h1, 32'(irq));
        fault <= 4'h0;
        wt(6);
        bus(0, ppo_pkg::ADDR_INT_STAT, 32'h1 << p);
        bus(1, ppo_pkg::ADDR_INT_STAT, 32'h1 << p);
        wt(3);
        chk("irq", 32'h0, 32'(irq));
        $display("Test overcurrent done");
        // New event on port 2 meets a clear in the same cycle: the event stays
        fault <= 4'h2;
        wt(2);
        bus(1, ppo_pkg::ADDR_INT_STAT, 32'h2);
        bus(0, ppo_pkg::ADDR_INT_STAT, 32'h2);
        wt(2);
        chk("irq", 32'h1, 32'(irq));
        $display("Test set over clear done");
        test_done;
    end
endmodule : test_ppo_power_ctl
